/* design/tmr_cfg.svh */
// Operation
// - enable register is 8 bits, loads 01 on reset and standby entry
// - enable bit 0 is reserved, always reads one, writes ignored
// - enable bits 7..4 gate capture flags A..D onto capture requests
// - enable bits 3 and 2 gate compare A and B flags onto requests
// - enable bit 1 gates overflow flag onto the overflow request
// - flag register is 8 bits, cleared to 00 on reset and standby
// - writing zero clears flags 7..1; writing one never sets them
// - a flag clears only after software read it as one first
// - capture A event sets flag 7; buffered mode shifts A into C
// - capture B event sets flag 6; buffered mode shifts B into D
// - input C edge sets flag 5; no capture while A is buffered
// - input D edge sets flag 4; no capture while B is buffered
// - counter equal to compare A sets flag 3
// - counter equal to compare B sets flag 2
// - counter wrap from maximum to zero sets flag 1
// - flag register bit 0 is plain read/write counter-clear control
// - with that bit one, compare match A returns counter to zero
// - edge select zero picks falling edge, one picks rising edge
// - buffered with differing edge selects, primary input uses both edges
`ifndef TMR_CFG_SVH
`define TMR_CFG_SVH
`define TMR_IDX_IRQ_EN    16'hff90
`define TMR_IDX_FLAGS     16'hff91
`define TMR_IRQ_EN_RESET  8'h01
`define TMR_FLAGS_RESET   8'h00
`define TMR_BIT_RESERVED  0
`define TMR_BIT_CLR_CMPA  0
`define TMR_BIT_OVF       1
`define TMR_BIT_CMPB      2
`define TMR_BIT_CMPA      3
`define TMR_BIT_CAPD      4
`define TMR_BIT_CAPC      5
`define TMR_BIT_CAPB      6
`define TMR_BIT_CAPA      7
`endif

/* design/tmr_pkg.sv */
package tmr_pkg;
    typedef logic [7:0]  tmr_byte_t;
    typedef logic [31:0] tmr_word_t;
    typedef logic [1:0]  tmr_trans_t;
    typedef logic [2:0]  tmr_size_t;
endpackage : tmr_pkg

/* design/tmr_irq_flags.sv */
// Register access over AHB-Lite was chosen for this implementation.
`timescale 1ns/100ps
`include "tmr_cfg.svh"
module tmr_irq_flags #(
    parameter int ADDR_W = 20
) (
    input  wire logic               hclk,
    input  wire logic               hresetn,
    input  wire logic               hsel,
    input  wire logic [ADDR_W-1:0]  haddr,
    input  wire tmr_pkg::tmr_trans_t htrans,
    input  wire logic               hwrite,
    input  wire tmr_pkg::tmr_size_t hsize,
    input  wire tmr_pkg::tmr_word_t hwdata,
    input  wire logic               hready,
    output tmr_pkg::tmr_word_t      hrdata,
    output logic                    hreadyout,
    output logic                    hresp,
    input  wire logic               standby,
    input  wire logic               capture_input_a,
    input  wire logic               capture_input_b,
    input  wire logic               capture_input_c,
    input  wire logic               capture_input_d,
    input  wire logic               edge_select_a,
    input  wire logic               edge_select_b,
    input  wire logic               edge_select_c,
    input  wire logic               edge_select_d,
    input  wire logic               buffer_a_enable,
    input  wire logic               buffer_b_enable,
    input  wire logic               compare_a_match,
    input  wire logic               compare_b_match,
    input  wire logic               count_wrap,
    output logic                    capture_a_irq,
    output logic                    capture_b_irq,
    output logic                    capture_c_irq,
    output logic                    capture_d_irq,
    output logic                    compare_a_irq,
    output logic                    compare_b_irq,
    output logic                    counter_overflow_irq,
    output logic                    capture_a_load,
    output logic                    capture_b_load,
    output logic                    capture_c_load,
    output logic                    capture_d_load,
    output logic                    shift_a_to_c,
    output logic                    shift_b_to_d,
    output logic                    counter_clear,
    output logic                    clear_on_compare_a
);
    import tmr_pkg::*;

    localparam logic [ADDR_W-1:0] ADDR_IRQ_EN =
        ADDR_W'({`TMR_IDX_IRQ_EN, 2'b00});
    localparam logic [ADDR_W-1:0] ADDR_FLAGS =
        ADDR_W'({`TMR_IDX_FLAGS, 2'b00});

    generate
        if (ADDR_W < 18)
        begin : g_bad_addr_w
            $error("ADDR_W too small for the register byte addresses");
        end
    endgenerate

    // edge of a synchronised input; sel one means rising
    function automatic logic edge_hit(input logic cur, input logic prev,
                                      input logic sel, input logic both);
        logic rise;
        logic fall;
        rise = cur & ~prev;
        fall = ~cur & prev;
        edge_hit = both ? (rise | fall) : (sel ? rise : fall);
    endfunction : edge_hit

    // two-stage synchronisers; stage one feeds stage two only
    logic [3:0] sync_1;
    logic [3:0] sync_2;
    logic [3:0] sync_prev;

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            sync_1    <= 4'h0;
            sync_2    <= 4'h0;
            sync_prev <= 4'h0;
        end
        else
        begin
            sync_1    <= {capture_input_d, capture_input_c,
                          capture_input_b, capture_input_a};
            sync_2    <= sync_1;
            sync_prev <= sync_2;
        end
    end

    logic cap_a;
    logic cap_b;
    logic cap_c;
    logic cap_d;

    always_comb
    begin
        // buffered and differing selects: primary input on both edges
        cap_a = edge_hit(sync_2[0], sync_prev[0], edge_select_a,
                         buffer_a_enable & (edge_select_a != edge_select_c));
        cap_b = edge_hit(sync_2[1], sync_prev[1], edge_select_b,
                         buffer_b_enable & (edge_select_b != edge_select_d));
        cap_c = edge_hit(sync_2[2], sync_prev[2], edge_select_c, 1'b0);
        cap_d = edge_hit(sync_2[3], sync_prev[3], edge_select_d, 1'b0);
    end

    // bus slave: zero wait states, data phase follows address phase
    logic            dp_wr_en;
    logic            dp_wr_flags;
    logic            dp_rd_flags;
    logic            next_dp_wr_en;
    logic            next_dp_wr_flags;
    logic            next_dp_rd_flags;
    tmr_word_t       next_hrdata;
    tmr_byte_t       irq_en;
    tmr_byte_t       flags;
    logic [7:1]      seen;
    tmr_byte_t       next_irq_en;
    tmr_byte_t       next_flags;
    logic [7:1]      next_seen;
    logic [7:1]      set_ev;
    logic [7:1]      clr;
    logic            addr_ok;

    always_comb
    begin
        addr_ok          = hsel & hready & htrans[1];
        next_dp_wr_en    = addr_ok & hwrite & (haddr == ADDR_IRQ_EN);
        next_dp_wr_flags = addr_ok & hwrite & (haddr == ADDR_FLAGS);
        next_dp_rd_flags = addr_ok & ~hwrite & (haddr == ADDR_FLAGS);
        next_hrdata      = 32'h0000_0000;
        // unmapped addresses read zero and ignore writes
        if (addr_ok & ~hwrite & (haddr == ADDR_IRQ_EN))
            next_hrdata[7:0] = irq_en;
        else if (next_dp_rd_flags)
            next_hrdata[7:0] = flags;
    end

    always_comb
    begin
        set_ev[`TMR_BIT_CAPA] = cap_a;
        set_ev[`TMR_BIT_CAPB] = cap_b;
        set_ev[`TMR_BIT_CAPC] = cap_c;
        set_ev[`TMR_BIT_CAPD] = cap_d;
        set_ev[`TMR_BIT_CMPA] = compare_a_match;
        set_ev[`TMR_BIT_CMPB] = compare_b_match;
        set_ev[`TMR_BIT_OVF]  = count_wrap;
        // a zero clears only a flag that was read as one; ones do nothing
        clr = {7{dp_wr_flags}} & ~hwdata[7:1] & seen;
        next_flags[7:1] = set_ev | (flags[7:1] & ~clr);
        next_flags[`TMR_BIT_CLR_CMPA] = dp_wr_flags ?
            hwdata[`TMR_BIT_CLR_CMPA] : flags[`TMR_BIT_CLR_CMPA];
        // a fresh event re-arms the read so an unseen set is not lost
        next_seen = next_flags[7:1] & ~set_ev &
                    ((seen & ~clr) |
                     ({7{dp_rd_flags}} & hrdata[7:1]));
        next_irq_en = dp_wr_en ? hwdata[7:0] : irq_en;
        next_irq_en[`TMR_BIT_RESERVED] = 1'b1;
        if (standby)
        begin
            next_flags  = `TMR_FLAGS_RESET;
            next_seen   = 7'h00;
            next_irq_en = `TMR_IRQ_EN_RESET;
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            dp_wr_en    <= 1'b0;
            dp_wr_flags <= 1'b0;
            dp_rd_flags <= 1'b0;
            hrdata      <= 32'h0000_0000;
            hreadyout   <= 1'b1;
            hresp       <= 1'b0;
            irq_en      <= `TMR_IRQ_EN_RESET;
            flags       <= `TMR_FLAGS_RESET;
            seen        <= 7'h00;
        end
        else
        begin
            dp_wr_en    <= next_dp_wr_en;
            dp_wr_flags <= next_dp_wr_flags;
            dp_rd_flags <= next_dp_rd_flags;
            hrdata      <= next_hrdata;
            hreadyout   <= 1'b1;
            hresp       <= 1'b0;
            irq_en      <= next_irq_en;
            flags       <= next_flags;
            seen        <= next_seen;
        end
    end

    // requests and clear_on_compare_a registered from next values so they match the registers
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            capture_a_irq        <= 1'b0;
            capture_b_irq        <= 1'b0;
            capture_c_irq        <= 1'b0;
            capture_d_irq        <= 1'b0;
            compare_a_irq        <= 1'b0;
            compare_b_irq        <= 1'b0;
            counter_overflow_irq <= 1'b0;
            capture_a_load       <= 1'b0;
            capture_b_load       <= 1'b0;
            capture_c_load       <= 1'b0;
            capture_d_load       <= 1'b0;
            shift_a_to_c         <= 1'b0;
            shift_b_to_d         <= 1'b0;
            counter_clear        <= 1'b0;
            clear_on_compare_a   <= 1'b0;
        end
        else
        begin
            capture_a_irq <= next_flags[7] & next_irq_en[7];
            capture_b_irq <= next_flags[6] & next_irq_en[6];
            capture_c_irq <= next_flags[5] & next_irq_en[5];
            capture_d_irq <= next_flags[4] & next_irq_en[4];
            compare_a_irq <= next_flags[3] & next_irq_en[3];
            compare_b_irq <= next_flags[2] & next_irq_en[2];
            counter_overflow_irq <= next_flags[1] & next_irq_en[1];
            capture_a_load <= cap_a;
            capture_b_load <= cap_b;
            shift_a_to_c   <= cap_a & buffer_a_enable;
            shift_b_to_d   <= cap_b & buffer_b_enable;
            capture_c_load <= cap_c & ~buffer_a_enable;
            capture_d_load <= cap_d & ~buffer_b_enable;
            // one cycle late; the counter block applies it on arrival
            counter_clear  <= compare_a_match &
                              flags[`TMR_BIT_CLR_CMPA];
            clear_on_compare_a <= next_flags[`TMR_BIT_CLR_CMPA];
        end
    end

    sequence s_flag_read(int b);
        dp_rd_flags && hrdata[b];
    endsequence

    sequence s_zero_write(int b);
        dp_wr_flags && !hwdata[b] && !set_ev[b] && !standby;
    endsequence

    a_enable_standby: assert property (
        @(posedge hclk) disable iff (!hresetn)
        standby |=> irq_en == 8'h01)
        else $error("enable register not reloaded by standby");

    a_reserved_one: assert property (
        @(posedge hclk) disable iff (!hresetn)
        irq_en[0] && hrdata[31:8] == 24'h0)
        else $error("reserved enable bit not one");

    a_capture_gate: assert property (
        @(posedge hclk) disable iff (!hresetn)
        {capture_a_irq, capture_b_irq, capture_c_irq, capture_d_irq}
            == (flags[7:4] & irq_en[7:4]))
        else $error("capture request not flag and enable");

    a_compare_gate: assert property (
        @(posedge hclk) disable iff (!hresetn)
        {compare_a_irq, compare_b_irq} == (flags[3:2] & irq_en[3:2]))
        else $error("compare request not flag and enable");

    a_overflow_gate: assert property (
        @(posedge hclk) disable iff (!hresetn)
        counter_overflow_irq == (flags[1] & irq_en[1]))
        else $error("overflow request not flag and enable");

    a_flags_standby: assert property (
        @(posedge hclk) disable iff (!hresetn)
        standby |=> flags == 8'h00)
        else $error("flags not cleared by standby");

    a_no_soft_set: assert property (
        @(posedge hclk) disable iff (!hresetn)
        !flags[7] && !set_ev[7] |=> !flags[7])
        else $error("flag set without a hardware event");

    a_read_then_clear: assert property (
        @(posedge hclk) disable iff (!hresetn)
        s_flag_read(3) ##1 (!dp_rd_flags && !dp_wr_flags)[*1]
            ##1 s_zero_write(3) |=> !flags[3])
        else $error("read then zero write did not clear flag");

    a_unread_kept: assert property (
        @(posedge hclk) disable iff (!hresetn)
        flags[2] && !seen[2] && dp_wr_flags && !standby |=> flags[2])
        else $error("unread flag cleared by a write");

    a_capture_sets: assert property (
        @(posedge hclk) disable iff (!hresetn)
        cap_a && !standby |=> flags[7] ##0 capture_a_load)
        else $error("capture A event did not set flag");

    a_compare_sets: assert property (
        @(posedge hclk) disable iff (!hresetn)
        compare_a_match && !standby |=> flags[3])
        else $error("compare A match did not set flag");

    a_wrap_sets: assert property (
        @(posedge hclk) disable iff (!hresetn)
        count_wrap && !standby |=> flags[1])
        else $error("counter wrap did not set flag");

    a_counter_clear: assert property (
        @(posedge hclk) disable iff (!hresetn)
        compare_a_match |=> counter_clear == $past(flags[0]))
        else $error("counter clear does not follow control bit");

    a_set_wins: assert property (
        @(posedge hclk) disable iff (!hresetn)
        set_ev[1] && dp_wr_flags && !standby |=> flags[1])
        else $error("event lost against a clear");

endmodule : tmr_irq_flags

/* tb/tmr_evt_src.sv */
`timescale 1ns/100ps
module tmr_evt_src (
    input  wire logic       hclk,
    input  wire logic       hresetn,
    input  wire logic       go,
    input  wire logic [2:0] kind,
    output logic            count_wrap,
    output logic            compare_b_match,
    output logic            compare_a_match,
    output logic            capture_input_a,
    output logic            capture_input_b,
    output logic            capture_input_c,
    output logic            capture_input_d
);
    // pins hold their level until the next command, well above the
    // pulse width that the synchroniser needs
    logic [7:4] pins;
    assign capture_input_a = pins[7];
    assign capture_input_b = pins[6];
    assign capture_input_c = pins[5];
    assign capture_input_d = pins[4];
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            count_wrap      <= 1'b0;
            compare_b_match <= 1'b0;
            compare_a_match <= 1'b0;
            pins            <= 4'h0;
        end
        else
        begin
            count_wrap      <= go && kind == 3'h1;
            compare_b_match <= go && kind == 3'h2;
            compare_a_match <= go && kind == 3'h3;
            for (int i = 4; i < 8; i++)
                if (go && kind == i[2:0])
                    pins[i] <= !pins[i];
        end
    end
endmodule : tmr_evt_src

/* tb/tmr_irq_flags_tb.sv */
`timescale 1ns/100ps
module tmr_irq_flags_tb;
    import tmr_pkg::*;
    localparam logic [19:0] A_EN = 20'h3fe40;
    localparam logic [19:0] A_FL = 20'h3fe44;
    logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp, standby;
    logic [19:0] haddr;
    tmr_trans_t  htrans;
    tmr_word_t   hwdata, hrdata, rd;
    logic        go;
    logic [2:0]  kind;
    logic        edge_select_a, edge_select_b, edge_select_c, edge_select_d;
    logic        buffer_a_enable, buffer_b_enable;
    logic        capture_input_a, capture_input_b;
    logic        capture_input_c, capture_input_d;
    logic        compare_a_match, compare_b_match, count_wrap;
    logic        capture_a_irq, capture_b_irq, capture_c_irq, capture_d_irq;
    logic        compare_a_irq, compare_b_irq, counter_overflow_irq;
    logic        counter_clear, clear_on_compare_a;
    tmr_byte_t   en, fl;
    logic [5:0]  ldv, ld;
    int          errors, checks, cyc, clr_seen;

    tmr_irq_flags #(.ADDR_W(20)) tmr_irq_flags_i (
        .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2),
        .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp, .standby,
        .capture_input_a, .capture_input_b, .capture_input_c,
        .capture_input_d, .edge_select_a, .edge_select_b, .edge_select_c,
        .edge_select_d, .buffer_a_enable, .buffer_b_enable,
        .compare_a_match, .compare_b_match, .count_wrap, .capture_a_irq,
        .capture_b_irq, .capture_c_irq, .capture_d_irq, .compare_a_irq,
        .compare_b_irq, .counter_overflow_irq, .capture_a_load(ldv[5]),
        .capture_b_load(ldv[4]), .capture_c_load(ldv[3]),
        .capture_d_load(ldv[2]), .shift_a_to_c(ldv[1]),
        .shift_b_to_d(ldv[0]), .counter_clear,
        .clear_on_compare_a);

    tmr_evt_src tmr_evt_src_i (
        .hclk, .hresetn, .go, .kind, .count_wrap, .compare_b_match,
        .compare_a_match, .capture_input_a, .capture_input_b,
        .capture_input_c, .capture_input_d);

    task automatic end_of_test;
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : end_of_test

    task automatic chk(input tmr_word_t got, input tmr_word_t exp);
        checks++;
        if (got !== exp)
        begin
            errors++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    // hready and hrdata are read at the rising edge itself, before the
    // slave's registers move on that edge
    task automatic bus(input logic wr, input logic [19:0] a,
                       input tmr_byte_t wd);
        hsel   <= 1'b1;
        haddr  <= a;
        htrans <= 2'h2;
        hwrite <= wr;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= {24'h0, wd};
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask : bus

    task automatic rchk(input logic [19:0] a, input tmr_byte_t e);
        bus(1'b0, a, 8'h00);
        chk(rd, {24'h0, e});
    endtask : rchk

    task automatic irq_chk;
        chk({25'h0, capture_a_irq, capture_b_irq, capture_c_irq,
             capture_d_irq, compare_a_irq, compare_b_irq,
             counter_overflow_irq}, {25'h0, fl[7:1] & en[7:1]});
    endtask : irq_chk

    // capture path takes three edges, the model one more
    task automatic ev(input logic [2:0] k);
        go   <= 1'b1;
        kind <= k;
        @(posedge hclk);
        go <= 1'b0;
        repeat (5) @(posedge hclk);
    endtask : ev

    task automatic t_regs;
        rchk(A_EN, 8'h01);
        chk({31'h0, hresp}, 32'h0);
        rchk(A_FL, 8'h00);
        rchk(20'h3fe48, 8'h00);
        bus(1'b1, A_EN, 8'h00);
        rchk(A_EN, 8'h01);
        bus(1'b1, A_EN, 8'haa);
        en = 8'hab;
        rchk(A_EN, en);
        $display("done: register access");
    endtask : t_regs

    task automatic t_events;
        fl = 8'h00;
        for (int k = 1; k < 8; k++)
        begin
            ev(k[2:0]);
            fl[k] = 1'b1;
            rchk(A_FL, fl);
            irq_chk();
        end
        chk(32'(clr_seen), 32'h0);
        chk({26'h0, ld}, 32'h3c);
        $display("done: event flags");
    endtask : t_events

    task automatic t_clear;
        ev(3'h3);
        ev(3'h2);
        bus(1'b1, A_FL, 8'h00);
        fl = 8'h0c;
        rchk(A_FL, fl);
        bus(1'b1, A_FL, 8'hfe);
        rchk(A_FL, fl);
        ev(3'h1);
        fl = 8'h0e;
        rchk(A_FL, fl);
        // the wrap pulse lands in the data phase of the clearing write
        fork
            bus(1'b1, A_FL, 8'h00);
            begin
                go   <= 1'b1;
                kind <= 3'h1;
                @(posedge hclk);
                go <= 1'b0;
            end
        join
        fl = 8'h02;
        rchk(A_FL, fl);
        bus(1'b1, A_FL, 8'h00);
        fl = 8'h00;
        rchk(A_FL, fl);
        irq_chk();
        $display("done: flag clearing");
    endtask : t_clear

    task automatic t_cclr;
        bus(1'b1, A_FL, 8'h01);
        fl = 8'h01;
        rchk(A_FL, fl);
        chk({31'h0, clear_on_compare_a}, 32'h1);
        clr_seen = 0;
        ev(3'h3);
        chk(32'(clr_seen), 32'h1);
        fl = 8'h09;
        rchk(A_FL, fl);
        irq_chk();
        bus(1'b1, A_FL, 8'h00);
        fl = 8'h00;
        rchk(A_FL, fl);
        ev(3'h3);
        chk(32'(clr_seen), 32'h1);
        $display("done: counter clear");
    endtask : t_cclr

    // all pins are high now: a falls with a falling select, b falls
    // while its select asks for a rising edge
    task automatic t_edge;
        edge_select_a <= 1'b0;
        edge_select_b <= 1'b1;
        @(posedge hclk);
        ev(3'h7);
        ev(3'h6);
        fl = 8'h88;
        rchk(A_FL, fl);
        $display("done: edge select");
    endtask : t_edge

    task automatic t_standby;
        standby <= 1'b1;
        @(posedge hclk);
        standby <= 1'b0;
        @(posedge hclk);
        en = 8'h01;
        fl = 8'h00;
        rchk(A_EN, en);
        rchk(A_FL, fl);
        irq_chk();
        $display("done: standby");
    endtask : t_standby

    // a: differing selects, so both edges; b: equal selects, rising only
    task automatic t_buffer;
        buffer_a_enable <= 1'b1;
        buffer_b_enable <= 1'b1;
        edge_select_a   <= 1'b1;
        edge_select_c   <= 1'b0;
        @(posedge hclk);
        ld = 6'h00;
        ev(3'h7);
        rchk(A_FL, 8'h80);
        bus(1'b1, A_FL, 8'h00);
        ev(3'h7);
        ev(3'h6);
        ev(3'h6);
        ev(3'h5);
        rchk(A_FL, 8'he0);
        chk({26'h0, ld}, 32'h33);
        $display("done: buffered capture");
    endtask : t_buffer

    always @(posedge hclk)
    begin
        if (counter_clear === 1'b1)
            clr_seen++;
        ld = ld | ldv;
        cyc++;
        if (cyc == 5000)
        begin
            errors++;
            end_of_test();
        end
    end

    initial
    begin
        hclk = 1'b0;
        forever #5 hclk = ~hclk;
    end

    initial
    begin
        {hsel, hwrite, standby, go, buffer_a_enable} = 5'h00;
        buffer_b_enable = 1'b0;
        {edge_select_a, edge_select_b} = 2'h3;
        {edge_select_c, edge_select_d} = 2'h3;
        haddr = 20'h00000;
        htrans = 2'h0;
        hwdata = 32'h0;
        kind = 3'h0;
        ld = 6'h00;
        hresetn = 1'b0;
        repeat (5) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        t_regs();
        t_events();
        t_clear();
        t_cclr();
        t_edge();
        t_standby();
        t_buffer();
        end_of_test();
    end
endmodule : tmr_irq_flags_tb
